// *** design/cwg_defs.vh ***
/*
 * Constants of the calibration waveform generator: register indices, byte
 * addresses, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from every design file of the block.
 */
`ifndef CWG_DEFS_VH
`define CWG_DEFS_VH

/**********************************************************************
 * Register indices and byte addresses (byte address = 4 x index).
 **********************************************************************/
`define CWG_IDX_CAL_CFG     8'h12
`define CWG_IDX_EMUX_CFG    8'h14
`define CWG_IDX_MSTR_CTRL   8'h20
`define CWG_IDX_STATUS      8'h21
`define CWG_ADDR_CAL_CFG    12'h048
`define CWG_ADDR_EMUX_CFG   12'h050
`define CWG_ADDR_MSTR_CTRL  12'h080
`define CWG_ADDR_STATUS     12'h084

/**********************************************************************
 * Calibration source configuration fields.
 **********************************************************************/
`define CWG_CAL_EN_BIT      22
`define CWG_CAL_POL_BIT     21
`define CWG_CAL_MAG_BIT     20
`define CWG_CAL_FREQ_MSB    14
`define CWG_CAL_FREQ_LSB    12
`define CWG_CAL_HALF_BIT    11
`define CWG_CAL_HIGH_MSB    10
`define CWG_CAL_HIGH_LSB    0
`define CWG_CAL_RESET       24'h004800
`define CWG_CAL_MASK        24'h707fff

/**********************************************************************
 * ECG input multiplexer configuration fields.
 **********************************************************************/
`define CWG_EMUX_POL_BIT    23
`define CWG_EMUX_OPENP_BIT  21
`define CWG_EMUX_OPENN_BIT  20
`define CWG_EMUX_CALP_MSB   19
`define CWG_EMUX_CALP_LSB   18
`define CWG_EMUX_CALN_MSB   17
`define CWG_EMUX_CALN_LSB   16
`define CWG_EMUX_RESET      24'h300000
`define CWG_EMUX_MASK       24'hbf0000

/**********************************************************************
 * Master frequency control and status fields.
 **********************************************************************/
`define CWG_MSTR_SEL_MSB    1
`define CWG_MSTR_SEL_LSB    0
`define CWG_MSTR_RESET      24'h000000
`define CWG_STAT_HIGH_BIT   0
`define CWG_STAT_ACT_BIT    1

/**********************************************************************
 * Timing: bus clock rate and the master clock rates in hertz.
 **********************************************************************/
`define CWG_HCLK_HZ         26'd40000000
`define CWG_MSTR_HZ_00      26'd32768
`define CWG_MSTR_HZ_01      26'd32000
`define CWG_MSTR_HZ_10      26'd32000
`define CWG_MSTR_HZ_11      26'd31968
`define CWG_DIV_BASE_LOG2   5'd7
`define CWG_DIV_STEP_LOG2   5'd2

/**********************************************************************
 * Source offsets in steps of 0.25 mV, two's complement.
 **********************************************************************/
`define CWG_MAG_SMALL       3'h1
`define CWG_MAG_LARGE       3'h2
`define CWG_LEVEL_MID       3'h0

`endif

// *** design/cwg_master_tick.v ***
/*
 * Master clock tick generator: a phase accumulator that yields the average
 * master rate as one-cycle ticks of the bus clock.
 * Assumes one bus clock and a clock enable that freezes the accumulator.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defs.vh"

module cwg_master_tick (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // Control.
  input  wire [1:0]  master_freq_select,
  // Tick.
  output reg         master_tick
);

  reg  [25:0] acc;
  reg  [25:0] step;
  wire [26:0] sum;

  /********************************************************************
   * The chosen master rate is added per cycle modulo the bus rate.
   ********************************************************************/
  always @* begin
    case (master_freq_select)
      2'h0:    step = `CWG_MSTR_HZ_00;
      2'h1:    step = `CWG_MSTR_HZ_01;
      2'h2:    step = `CWG_MSTR_HZ_10;
      default: step = `CWG_MSTR_HZ_11;
    endcase
  end

  assign sum = {1'b0, acc} + {1'b0, step};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc         <= 26'h0;
      master_tick <= 1'b0;
    end else if (clk_en) begin
      if (sum >= {1'b0, `CWG_HCLK_HZ}) begin
        acc         <= sum[25:0] - `CWG_HCLK_HZ;
        master_tick <= 1'b1;
      end else begin
        acc         <= sum[25:0];
        master_tick <= 1'b0;
      end
    end
  end

endmodule // cwg_master_tick
`default_nettype wire

// *** design/cwg_wave_timer.v ***
/*
 * Waveform timer: counts master ticks over one period and decides the high
 * and low phases.
 * Assumes master ticks of one bus cycle and a clock enable that freezes it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defs.vh"

module cwg_wave_timer (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // Timing inputs.
  input  wire        master_tick,
  input  wire        run,
  input  wire [2:0]  cal_frequency_select,
  input  wire        half_duty_mode,
  input  wire [10:0] cal_high_time,
  // Waveform.
  output reg         wave_high,
  output reg         period_start
);

  reg  [20:0] count;
  wire [4:0]  div_log2;
  wire [21:0] divisor;
  wire [20:0] last;
  wire [20:0] high_len;

  /********************************************************************
   * Divisor is two to the power 7, 9, 11 ... 21.
   ********************************************************************/
  assign div_log2 = `CWG_DIV_BASE_LOG2 + (`CWG_DIV_STEP_LOG2 * {2'b00, cal_frequency_select});
  assign divisor  = 22'h000001 << div_log2;
  assign last     = divisor[20:0] - 21'h000001;
  assign high_len = half_duty_mode ? divisor[21:1] : {10'h000, cal_high_time};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count        <= 21'h0;
      wave_high    <= 1'b0;
      period_start <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count        <= last;
        wave_high    <= 1'b0;
        period_start <= 1'b0;
      end else if (master_tick) begin
        if (count >= last) begin
          count        <= 21'h0;
          period_start <= 1'b1;
          wave_high    <= (high_len != 21'h0);
        end else begin
          count        <= count + 21'h000001;
          period_start <= 1'b0;
          wave_high    <= ((count + 21'h000001) < high_len);
        end
      end else begin
        period_start <= 1'b0;
      end
    end
  end

endmodule // cwg_wave_timer
`default_nettype wire

// *** design/cwg_top.v ***
/*
 * Calibration waveform generator: AHB-Lite register slave, master tick,
 * period timer and the levels of the two calibration sources.
 * Assumes a single AHB-Lite master, one clock and software-set configuration.
 */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defs.vh"

module cwg_top (
  // Clock, reset and clock enable.
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Calibration sources, offsets from mid supply in 0.25 mV steps.
  output reg  [2:0]  cal_source_pos,
  output reg  [2:0]  cal_source_neg,
  output reg         cal_sources_active,
  output reg         cal_period_start,
  // ECG input multiplexer controls.
  output reg         ecg_polarity_invert,
  output reg         ecg_pos_open,
  output reg         ecg_neg_open,
  output reg  [1:0]  ecg_pos_cal_route,
  output reg  [1:0]  ecg_neg_cal_route
);

  /********************************************************************
   * Bus data phase states.
   ********************************************************************/
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_READ  = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [11:0] wr_addr;
  reg  [11:0] next_wr_addr;
  reg  [23:0] cal_cfg;
  reg  [23:0] emux_cfg;
  reg  [23:0] mstr_ctrl;
  reg  [31:0] rd_value;
  wire        addr_phase;
  wire        master_tick;
  wire        wave_high;
  wire        wave_start;
  wire        cal_source_enable;
  wire        cal_polarity_mode;
  wire        cal_swing_magnitude;
  wire [2:0]  cal_frequency_select;
  wire        half_duty_mode;
  wire [10:0] cal_high_time;
  wire [1:0]  master_freq_select;
  wire [2:0]  mag;
  reg  [2:0]  next_pos;
  wire [1:0]  pos_route;
  wire [1:0]  neg_route;

  /********************************************************************
   * Configuration fields.
   ********************************************************************/
  assign cal_source_enable    = cal_cfg[`CWG_CAL_EN_BIT];
  assign cal_polarity_mode    = cal_cfg[`CWG_CAL_POL_BIT];
  assign cal_swing_magnitude  = cal_cfg[`CWG_CAL_MAG_BIT];
  assign cal_frequency_select = cal_cfg[`CWG_CAL_FREQ_MSB:`CWG_CAL_FREQ_LSB];
  assign half_duty_mode       = cal_cfg[`CWG_CAL_HALF_BIT];
  assign cal_high_time        = cal_cfg[`CWG_CAL_HIGH_MSB:`CWG_CAL_HIGH_LSB];
  assign master_freq_select   = mstr_ctrl[`CWG_MSTR_SEL_MSB:`CWG_MSTR_SEL_LSB];

  /********************************************************************
   * Bus slave: zero wait states, always OKAY, stalls while frozen.
   ********************************************************************/
  assign hreadyout  = clk_en;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;

  always @* begin
    case (haddr)
      `CWG_ADDR_CAL_CFG:   rd_value = {8'h00, cal_cfg};
      `CWG_ADDR_EMUX_CFG:  rd_value = {8'h00, emux_cfg};
      `CWG_ADDR_MSTR_CTRL: rd_value = {8'h00, mstr_ctrl};
      `CWG_ADDR_STATUS:    rd_value = {30'h00000000, cal_sources_active, wave_high};
      default:             rd_value = 32'h00000000;
    endcase
  end

  always @* begin
    next_state   = ST_IDLE;
    next_wr_addr = wr_addr;
    case (state)
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (addr_phase && hwrite) begin
          next_state   = ST_WRITE;
          next_wr_addr = haddr;
        end else if (addr_phase) begin
          next_state = ST_READ;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      wr_addr <= 12'h000;
      hrdata  <= 32'h00000000;
    end else if (clk_en) begin
      state   <= next_state;
      wr_addr <= next_wr_addr;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  /********************************************************************
   * Registers, written at the end of the write data phase.
   ********************************************************************/
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_cfg   <= `CWG_CAL_RESET;
      emux_cfg  <= `CWG_EMUX_RESET;
      mstr_ctrl <= `CWG_MSTR_RESET;
    end else if (clk_en && (state == ST_WRITE)) begin
      case (wr_addr)
        `CWG_ADDR_CAL_CFG:   cal_cfg   <= hwdata[23:0] & `CWG_CAL_MASK;
        `CWG_ADDR_EMUX_CFG:  emux_cfg  <= hwdata[23:0] & `CWG_EMUX_MASK;
        `CWG_ADDR_MSTR_CTRL: mstr_ctrl <= {22'h000000, hwdata[1:0]};
        default:             mstr_ctrl <= mstr_ctrl;
      endcase
    end
  end

  /********************************************************************
   * Master tick and period timer.
   ********************************************************************/
  cwg_master_tick u_tick (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .clk_en             (clk_en),
    .master_freq_select (master_freq_select),
    .master_tick        (master_tick)
  );

  cwg_wave_timer u_timer (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .clk_en               (clk_en),
    .master_tick          (master_tick),
    .run                  (cal_source_enable),
    .cal_frequency_select (cal_frequency_select),
    .half_duty_mode       (half_duty_mode),
    .cal_high_time        (cal_high_time),
    .wave_high            (wave_high),
    .period_start         (wave_start)
  );

  /********************************************************************
   * Source levels.
   ********************************************************************/
  assign mag = cal_swing_magnitude ? `CWG_MAG_LARGE : `CWG_MAG_SMALL;

  always @* begin
    if (!cal_source_enable) begin
      next_pos = `CWG_LEVEL_MID;
    end else if (wave_high) begin
      next_pos = mag;
    end else if (cal_polarity_mode) begin
      next_pos = 3'h0 - mag;
    end else begin
      next_pos = `CWG_LEVEL_MID;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_source_pos     <= `CWG_LEVEL_MID;
      cal_source_neg     <= `CWG_LEVEL_MID;
      cal_sources_active <= 1'b0;
      cal_period_start   <= 1'b0;
    end else if (clk_en) begin
      cal_source_pos     <= next_pos;
      cal_source_neg     <= 3'h0 - next_pos;
      cal_sources_active <= cal_source_enable;
      cal_period_start   <= wave_start;
    end
  end

  /********************************************************************
   * ECG multiplexer controls; source routes need the sources enabled.
   ********************************************************************/
  assign pos_route = emux_cfg[`CWG_EMUX_CALP_MSB:`CWG_EMUX_CALP_LSB];
  assign neg_route = emux_cfg[`CWG_EMUX_CALN_MSB:`CWG_EMUX_CALN_LSB];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ecg_polarity_invert <= 1'b0;
      ecg_pos_open        <= 1'b1;
      ecg_neg_open        <= 1'b1;
      ecg_pos_cal_route   <= 2'h0;
      ecg_neg_cal_route   <= 2'h0;
    end else if (clk_en) begin
      ecg_polarity_invert <= emux_cfg[`CWG_EMUX_POL_BIT];
      ecg_pos_open        <= emux_cfg[`CWG_EMUX_OPENP_BIT];
      ecg_neg_open        <= emux_cfg[`CWG_EMUX_OPENN_BIT];
      ecg_pos_cal_route   <= (pos_route[1] && !cal_source_enable) ? 2'h0 : pos_route;
      ecg_neg_cal_route   <= (neg_route[1] && !cal_source_enable) ? 2'h0 : neg_route;
    end
  end

endmodule // cwg_top
`default_nettype wire

// *** bench/cwg_top_properties.sv ***
/* Port checker for the calibration waveform generator.
 * Assumes it is bound to cwg_top and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defs.vh"
module cwg_top_properties (
  // Clock and bus.
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Sources and routes.
  input wire logic [2:0]  cal_source_pos,
  input wire logic [2:0]  cal_source_neg,
  input wire logic        cal_sources_active,
  input wire logic [1:0]  ecg_pos_cal_route,
  input wire logic [1:0]  ecg_neg_cal_route
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go  = hsel && htrans[1] && hready && !hwrite;
  wire rd_cal = rd_go && haddr == `CWG_ADDR_CAL_CFG;
  wire rd_bad = rd_go && haddr == 12'h0fc;
  property p_mirror; cal_source_neg == 3'h0 - cal_source_pos; endproperty
  a_mirror: assert property (p_mirror) else $error("negative source not mirrored");
  property p_legal; cal_source_pos inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7}; endproperty
  a_legal: assert property (p_legal) else $error("source level out of range");
  property p_idle; $fell(cal_sources_active) |-> ##[0:2] (cal_source_pos == 3'h0) [*4]; endproperty
  a_idle: assert property (p_idle) else $error("sources not at mid when disabled");
  property p_gate; !cal_sources_active ##1 !cal_sources_active
    |-> !$past(ecg_pos_cal_route[1]) && !$past(ecg_neg_cal_route[1]); endproperty
  a_gate: assert property (p_gate) else $error("source route open while disabled");
  property p_hold; $changed(cal_source_pos) && cal_sources_active && $past(cal_sources_active)
    |=> $stable(cal_source_pos) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("level changed between ticks");
  property p_ready; hreadyout == clk_en && hresp == 1'b0; endproperty
  a_ready: assert property (p_ready) else $error("ready or response wrong");
  property p_freeze; !clk_en |=> $stable(cal_source_pos) && $stable(hrdata); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_unmapped; rd_bad |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reserved; rd_cal |=> (hrdata & ~{8'h00, `CWG_CAL_MASK}) == 32'h0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
  c_enable: cover property ($rose(cal_sources_active));
  c_bipolar: cover property (cal_source_pos == 3'h6);
  c_unmapped: cover property (rd_bad);
endmodule // cwg_top_properties
bind cwg_top cwg_top_properties u_props (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .cal_source_pos, .cal_source_neg,
  .cal_sources_active, .ecg_pos_cal_route, .ecg_neg_cal_route);
`default_nettype wire

// *** bench/cwg_mux_model.sv ***
/* Channel input multiplexer model: puts mid supply, a source or a floating
 * level on each channel input, as offsets in 0.25 mV steps.
 * Assumes the route outputs and source levels of cwg_top. */
`timescale 1ns/1ps
`default_nettype none
module cwg_mux_model (
  // Clock.
  input  wire logic       hclk,
  // Routes and sources.
  input  wire logic [1:0] pos_route,
  input  wire logic [1:0] neg_route,
  input  wire logic [2:0] src_pos,
  input  wire logic [2:0] src_neg,
  // Channel input levels.
  output wire logic [2:0] pos_level,
  output wire logic [2:0] neg_level
);
  logic [2:0] flt = 3'h3;
  // An unrouted input floats between two levels that no source ever drives.
  always @(posedge hclk) begin
    flt <= ~flt;
  end
  function automatic logic [2:0] pick(input logic [1:0] r, input logic [2:0] p, n, f);
    case (r)
      2'b01: return 3'h0;
      2'b10: return p;
      2'b11: return n;
      default: return f;
    endcase
  endfunction
  assign pos_level = pick(pos_route, src_pos, src_neg, flt);
  assign neg_level = pick(neg_route, src_pos, src_neg, flt);
endmodule // cwg_mux_model
`default_nettype wire

// *** bench/calibration_waveform_generator_tb.sv ***
/* Self-checking testbench of the calibration waveform generator.
 * Assumes cwg_top, the bound checker and the multiplexer model. */
`timescale 1ns/1ps
`default_nettype none
module calibration_waveform_generator_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire         hreadyout, hresp, act, pol_inv, popen, nopen, pstart;
  wire  [31:0] hrdata;
  wire  [2:0]  src_p, src_n, lvl_p, lvl_n;
  wire  [1:0]  rt_p, rt_n;
  int          errors = 0;
  int          samples_checked = 0;
  always #12.5 hclk = ~hclk;
  cwg_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cal_source_pos(src_p),
    .cal_source_neg(src_n), .cal_sources_active(act), .cal_period_start(pstart),
    .ecg_polarity_invert(pol_inv), .ecg_pos_open(popen), .ecg_neg_open(nopen),
    .ecg_pos_cal_route(rt_p), .ecg_neg_cal_route(rt_n));
  cwg_mux_model u_mux (.hclk(hclk), .pos_route(rt_p), .neg_route(rt_n), .src_pos(src_p),
    .src_neg(src_n), .pos_level(lvl_p), .neg_level(lvl_n));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("unexpected count at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_ready(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd);
    int n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n);
    rd = hrdata;
  endtask
  task automatic wait_level(input logic [2:0] lvl, input int lim, output int n);
    n = 0;
    while (lvl_p !== lvl && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic t_reset();
    bus(12'h048, 1'b0, 32'h0);
    check_word(rd, 32'h00004800);
    bus(12'h050, 1'b0, 32'h0);
    check_word(rd, 32'h00300000);
    bus(12'h080, 1'b0, 32'h0);
    check_word(rd, 32'h00000000);
    check_word({23'h0, src_p, pol_inv, popen, nopen, act, rt_p}, 32'h018);
    $display("reset test done");
  endtask
  task automatic t_fields();
    bus(12'h050, 1'b1, 32'hffffffff);
    bus(12'h050, 1'b0, 32'h0);
    check_word(rd, 32'h00bf0000);
    check_word({29'h0, pol_inv, popen, nopen}, 32'h7);
    check_word({28'h0, rt_p, rt_n}, 32'h0);
    bus(12'h048, 1'b1, 32'hffbfffff);
    bus(12'h048, 1'b0, 32'h0);
    check_word(rd, 32'h00307fff);
    check_word({29'h0, src_p}, 32'h0);
    bus(12'h0fc, 1'b1, 32'hffffffff);
    bus(12'h0fc, 1'b0, 32'h0);
    check_word(rd, 32'h0);
    $display("field test done");
  endtask
  task automatic t_wave(input logic [1:0] msel, input logic [31:0] cfg,
                        input logic [2:0] hi, input logic [2:0] lo, input int cyc);
    int n;
    bus(12'h048, 1'b1, 32'h0);
    bus(12'h080, 1'b1, {30'h0, msel});
    bus(12'h050, 1'b1, 32'h003b0000);
    bus(12'h048, 1'b1, cfg);
    wait_level(hi, 4000, n);
    check_count(n, 0, 3999);
    check_word({31'h0, pstart}, 32'h1);
    check_word({29'h0, lvl_n}, {29'h0, 3'h0 - hi});
    check_word({28'h0, rt_p, rt_n}, 32'hb);
    wait_level(lo, cyc + 10, n);
    check_count(n, cyc - 3, cyc + 3);
    check_word({29'h0, lvl_n}, {29'h0, 3'h0 - lo});
    bus(12'h084, 1'b0, 32'h0);
    check_word(rd, 32'h00000002);
    wait_level(hi, 4000, n);
    check_count(n, 4000, 4000);
    $display("wave test done, master select %0d", msel);
  endtask
  task automatic t_half();
    int n;
    bus(12'h048, 1'b1, 32'h0);
    bus(12'h048, 1'b1, 32'h00400802);
    wait_level(3'h1, 4000, n);
    check_count(n, 0, 3999);
    wait_level(3'h0, 2600, n);
    check_count(n, 2600, 2600);
    $display("half duty test done");
  endtask
  task automatic t_stop();
    clk_en <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    check_word({31'h0, hreadyout}, 32'h0);
    @(posedge hclk);
    clk_en <= 1'b1;
    bus(12'h048, 1'b1, 32'h0);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check_word({26'h0, src_p, act, rt_p}, 32'h0);
    @(posedge hclk);
    $display("disable test done");
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_fields();
    t_wave(2'h0, 32'h00400002, 3'h1, 3'h0, 2 * 40000000 / 32768);
    t_wave(2'h3, 32'h00700002, 3'h2, 3'h6, 2 * 40000000 / 31968);
    t_half();
    t_stop();
    report_and_stop();
  end
endmodule // calibration_waveform_generator_tb
`default_nettype wire
